/* src/i2cf_rx_fifo.sv */
// Notes on behaviour
// - hardware general call reports type 10b
// - length field holds write-to-slave payload count
// - length counts bytes actually moved
// - write-to-slave past 2047: nack, set overflow
// - read-from-slave past 2047: length wraps
// - bit 29 shows which address matched
// - dual bit cleared by stop/restart/bus error/disable
// - data port read pops one byte
// - full rx fifo stretches scl low
// - write-to-slave address raises request flag
// - dma single requests follow rx entries
// - tx nearly-empty when count <= limit
// - rx nearly-full when count >= limit
// - op codes: 10b write, 11b read
// - overflow reports abort cause 110b
`timescale 1ns/1ns
module i2cf_rx_fifo (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [9:0]  tx_fifo_count,
    input  wire logic [7:0]  tx_byte,
    output logic             tx_pop,
    output logic             rx_dma_req
);
    typedef struct packed {
        i2cf_pkg::i2cf_state_t st;
        logic                  scl_q;
        logic                  sda_q;
        logic [7:0]            shreg;
        logic [7:0]            txsh;
        logic [3:0]            bitcnt;
        logic                  first;
        logic [15:0][7:0]      mem;
        logic [3:0]            wp;
        logic [3:0]            rp;
        logic [4:0]            cnt;
        logic [10:0]           length;
        logic [1:0]            op;
        logic [1:0]            stat;
        logic [2:0]            cause;
        logic [1:0]            rtype;
        logic                  dual;
        logic [2:0]            ctrl;
        logic [6:0]            sa;
        logic [6:0]            dsa;
        logic [9:0]            txthr;
        logic [9:0]            rxthr;
        logic [3:0]            raw;
        logic [3:0]            mask;
        logic [31:0]           rdata;
        logic                  irq;
        logic                  scl_oe;
        logic                  sda_oe;
        logic                  tx_pop;
        logic                  dma_req;
    } i2cf_core_t;

    i2cf_core_t s;
    i2cf_core_t next_s;
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic       push;
    logic       pop;
    logic [7:0] push_byte;
    logic [6:0] rx_addr;
    logic       hit_sa;
    logic       hit_dsa;
    logic       hit_gc;
    logic       full;

    // bus pins are asynchronous to clk
    i2cf_sync #(.W(2)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({scl_in, sda_in}),
        .dout (pins_s)
    );

    // line events from synchronised samples
    assign scl_s   = pins_s[1];
    assign sda_s   = pins_s[0];
    assign rise    = scl_s && !s.scl_q;
    assign fall    = !scl_s && s.scl_q;
    assign start_c = scl_s && s.scl_q && s.sda_q && !sda_s;
    assign stop_c  = scl_s && s.scl_q && !s.sda_q && sda_s;
    assign rx_addr = s.shreg[7:1];
    assign hit_sa  = rx_addr == s.sa;
    assign hit_dsa = rx_addr == s.dsa;
    assign hit_gc  = rx_addr == 7'h00 && s.ctrl[i2cf_pkg::I2CF_CTRL_GCALL] && !s.shreg[0];
    assign full    = s.cnt == i2cf_pkg::I2CF_RX_FULL;

    // whole next state; register side first, then the slave engine
    always_comb
    begin
        next_s         = s;
        next_s.scl_q   = scl_s;
        next_s.sda_q   = sda_s;
        next_s.tx_pop  = 1'b0;
        next_s.rdata   = 32'h0000_0000;
        push           = 1'b0;
        pop            = 1'b0;
        push_byte      = 8'h00;
        // lsb of the fifo byte is the first bit seen on the line
        for (int i = 0; i < 8; i++)
            push_byte[i] = s.shreg[7 - i];

        // register writes, reserved bits dropped
        if (wr)
        begin
            unique case (addr)
                i2cf_pkg::I2CF_CTRL_OFS:  next_s.ctrl  = wdata[2:0];
                i2cf_pkg::I2CF_SADDR_OFS:
                begin
                    next_s.sa  = wdata[i2cf_pkg::I2CF_SA_LSB +: 7];
                    next_s.dsa = wdata[i2cf_pkg::I2CF_DSA_LSB +: 7];
                end
                i2cf_pkg::I2CF_MASK_OFS:  next_s.mask  = wdata[3:0];
                i2cf_pkg::I2CF_TXTHR_OFS: next_s.txthr = wdata[9:0];
                i2cf_pkg::I2CF_RXTHR_OFS: next_s.rxthr = wdata[9:0];
                default: ;
            endcase
        end

        // register reads, answer in the next cycle
        if (rd)
        begin
            unique case (addr)
                i2cf_pkg::I2CF_CTRL_OFS:  next_s.rdata[2:0] = s.ctrl;
                i2cf_pkg::I2CF_SADDR_OFS:
                begin
                    next_s.rdata[i2cf_pkg::I2CF_SA_LSB +: 7]  = s.sa;
                    next_s.rdata[i2cf_pkg::I2CF_DSA_LSB +: 7] = s.dsa;
                end
                i2cf_pkg::I2CF_RAW_OFS:
                begin
                    next_s.rdata[3:0] = s.raw;
                    next_s.raw        = 4'h0; // read clears; sets below win
                end
                i2cf_pkg::I2CF_MASK_OFS:  next_s.rdata[3:0] = s.mask;
                i2cf_pkg::I2CF_STAT_OFS:
                begin
                    next_s.rdata[i2cf_pkg::I2CF_ST_OP_LSB +: 2]    = s.op;
                    next_s.rdata[i2cf_pkg::I2CF_ST_STAT_LSB +: 2]  = s.stat;
                    next_s.rdata[i2cf_pkg::I2CF_ST_CAUSE_LSB +: 3] = s.cause;
                    next_s.rdata[i2cf_pkg::I2CF_ST_TYPE_LSB +: 2]  = s.rtype;
                    next_s.rdata[i2cf_pkg::I2CF_ST_LEN_LSB +: 11]  = s.length;
                    next_s.rdata[i2cf_pkg::I2CF_ST_DUAL]           = s.dual;
                end
                i2cf_pkg::I2CF_RXDATA_OFS:
                begin
                    if (s.cnt != 5'h00)
                    begin
                        next_s.rdata[7:0] = s.mem[s.rp];
                        pop               = 1'b1;
                    end
                end
                i2cf_pkg::I2CF_TXTHR_OFS: next_s.rdata[9:0] = s.txthr;
                i2cf_pkg::I2CF_RXTHR_OFS: next_s.rdata[9:0] = s.rxthr;
                default: ;
            endcase
        end

        // slave engine: disable flushes, then start/stop, then bit phases
        if (!s.ctrl[i2cf_pkg::I2CF_CTRL_PE])
        begin
            next_s.st     = i2cf_pkg::I2CF_IDLE;
            next_s.dual   = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.sda_oe = 1'b0;
            next_s.wp     = 4'h0;
            next_s.rp     = 4'h0;
            next_s.cnt    = 5'h00;
            pop           = 1'b0;
        end
        else if (start_c || stop_c)
        begin
            // a start or stop inside a data byte is a bus error; the one rise that
            // a normal stop or repeated start always makes is not
            if ((s.st == i2cf_pkg::I2CF_WRX || s.st == i2cf_pkg::I2CF_TX) && s.bitcnt > 4'h1)
            begin
                next_s.stat  = i2cf_pkg::I2CF_STAT_ABORT;
                next_s.cause = start_c ? i2cf_pkg::I2CF_CAUSE_BSTART
                                       : i2cf_pkg::I2CF_CAUSE_BSTOP;
            end
            else if (stop_c && s.stat == i2cf_pkg::I2CF_STAT_BUSY)
                next_s.stat = i2cf_pkg::I2CF_STAT_OK;
            next_s.dual   = 1'b0;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.bitcnt = 4'h0;
            next_s.st     = start_c ? i2cf_pkg::I2CF_ADDR : i2cf_pkg::I2CF_IDLE;
        end
        else
        begin
            unique case (s.st)
                i2cf_pkg::I2CF_IDLE: ;
                i2cf_pkg::I2CF_ADDR:
                begin
                    if (rise)
                    begin
                        next_s.shreg  = {s.shreg[6:0], sda_s};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end
                    else if (fall && s.bitcnt == 4'h8)
                    begin
                        if (hit_sa || hit_dsa || hit_gc)
                        begin
                            next_s.sda_oe = 1'b1;
                            next_s.dual   = hit_dsa && !hit_sa;
                            next_s.op     = s.shreg[0] ? i2cf_pkg::I2CF_OP_RFS
                                                       : i2cf_pkg::I2CF_OP_WTS;
                            next_s.stat   = i2cf_pkg::I2CF_STAT_BUSY;
                            next_s.cause  = i2cf_pkg::I2CF_CAUSE_NONE;
                            next_s.length = 11'h000;
                            next_s.rtype  = hit_gc ? i2cf_pkg::I2CF_TYPE_GCALL
                                                   : i2cf_pkg::I2CF_TYPE_FRAME;
                            next_s.first  = 1'b1;
                            if (!s.shreg[0])
                                next_s.raw[i2cf_pkg::I2CF_IRQ_WREQ] = 1'b1;
                            next_s.st     = i2cf_pkg::I2CF_ACK;
                        end
                        else
                            next_s.st = i2cf_pkg::I2CF_IDLE;
                    end
                end
                i2cf_pkg::I2CF_ACK:
                begin
                    if (fall)
                    begin
                        next_s.bitcnt = 4'h0;
                        if (s.op == i2cf_pkg::I2CF_OP_RFS)
                        begin
                            next_s.txsh   = tx_byte;
                            next_s.tx_pop = 1'b1;
                            next_s.sda_oe = !tx_byte[7];
                            next_s.st     = i2cf_pkg::I2CF_TX;
                        end
                        else
                        begin
                            next_s.sda_oe = 1'b0;
                            next_s.st     = i2cf_pkg::I2CF_WRX;
                        end
                    end
                end
                i2cf_pkg::I2CF_WRX:
                begin
                    if (rise)
                    begin
                        next_s.shreg  = {s.shreg[6:0], sda_s};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end
                    else if (fall && s.bitcnt == 4'h8)
                    begin
                        if (s.length == i2cf_pkg::I2CF_LEN_MAX)
                        begin
                            // byte 2048 is refused: line left high as nack
                            next_s.stat  = i2cf_pkg::I2CF_STAT_ABORT;
                            next_s.cause = i2cf_pkg::I2CF_CAUSE_SLAVE_WRITE_OVERFLOW;
                            next_s.raw[i2cf_pkg::I2CF_IRQ_OVF] = 1'b1;
                            next_s.st    = i2cf_pkg::I2CF_IDLE;
                        end
                        else if (full)
                        begin
                            next_s.scl_oe = 1'b1;
                            next_s.st     = i2cf_pkg::I2CF_STRETCH;
                        end
                        else
                        begin
                            push          = 1'b1;
                            next_s.sda_oe = 1'b1;
                            next_s.st     = i2cf_pkg::I2CF_ACK;
                        end
                    end
                end
                i2cf_pkg::I2CF_STRETCH:
                begin
                    // hold scl until software or dma frees an entry
                    if (!full || pop)
                    begin
                        push          = 1'b1;
                        next_s.sda_oe = 1'b1;
                        next_s.scl_oe = 1'b0;
                        next_s.st     = i2cf_pkg::I2CF_ACK;
                    end
                end
                i2cf_pkg::I2CF_TX:
                begin
                    if (rise)
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    else if (fall)
                    begin
                        if (s.bitcnt == 4'h8)
                        begin
                            next_s.sda_oe = 1'b0;
                            next_s.length = s.length + 11'h001; // wraps past 2047
                            next_s.st     = i2cf_pkg::I2CF_MACK;
                        end
                        else
                        begin
                            next_s.txsh   = {s.txsh[6:0], 1'b0};
                            next_s.sda_oe = !s.txsh[6];
                        end
                    end
                end
                i2cf_pkg::I2CF_MACK:
                begin
                    if (rise)
                    begin
                        if (sda_s)
                            next_s.st = i2cf_pkg::I2CF_IDLE; // master nack ends reading
                        else
                            next_s.bitcnt = 4'h9;
                    end
                    else if (fall && s.bitcnt == 4'h9)
                    begin
                        next_s.bitcnt = 4'h0;
                        next_s.txsh   = tx_byte;
                        next_s.tx_pop = 1'b1;
                        next_s.sda_oe = !tx_byte[7];
                        next_s.st     = i2cf_pkg::I2CF_TX;
                    end
                end
                default: next_s.st = i2cf_pkg::I2CF_IDLE;
            endcase
        end

        // fifo store, pointers and payload count
        if (push)
        begin
            next_s.mem[s.wp] = push_byte;
            next_s.wp        = s.wp + 4'h1;
            next_s.length    = s.length + 11'h001;
            next_s.first     = 1'b0;
            if (s.first && s.rtype == i2cf_pkg::I2CF_TYPE_GCALL && s.shreg[0])
                next_s.rtype = i2cf_pkg::I2CF_TYPE_HWGC;
        end
        if (pop)
            next_s.rp = s.rp + 4'h1;
        next_s.cnt = next_s.cnt + {4'h0, push} - {4'h0, pop};

        // level flags set every cycle they hold while the engine is enabled, so a clearing read loses
        if (s.ctrl[i2cf_pkg::I2CF_CTRL_PE])
        begin
            if (tx_fifo_count <= s.txthr)
                next_s.raw[i2cf_pkg::I2CF_IRQ_TXNE] = 1'b1;
            if ({5'h00, s.cnt} >= s.rxthr)
                next_s.raw[i2cf_pkg::I2CF_IRQ_RXNF] = 1'b1;
        end

        // dma asks while entries remain; one pop per read keeps it honest
        next_s.dma_req = s.ctrl[i2cf_pkg::I2CF_CTRL_DMA] && next_s.cnt != 5'h00;
        next_s.irq     = |(next_s.raw & next_s.mask);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s       <= '0;
            s.st    <= i2cf_pkg::I2CF_IDLE;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            s.ctrl  <= i2cf_pkg::I2CF_CTRL_RST;
            s.sa    <= i2cf_pkg::I2CF_SA_RST;
            s.dsa   <= i2cf_pkg::I2CF_SA_RST;
            s.txthr <= i2cf_pkg::I2CF_THR_RST;
            s.rxthr <= i2cf_pkg::I2CF_THR_RST;
        end
        else
            s <= next_s;
    end

    // outputs straight from the state register; lines only pulled low
    assign rdata      = s.rdata;
    assign irq        = s.irq;
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe     = s.scl_oe;
    assign sda_oe     = s.sda_oe;
    assign tx_pop     = s.tx_pop;
    assign rx_dma_req = s.dma_req;

    // checks next to the logic
    hardware_general_call_a: assert property (@(posedge clk) disable iff (rst)
        (push && s.first && s.rtype == 2'h1 && s.shreg[0]) |=> s.rtype == 2'h2)
        else $error("hardware general call type not reported");
    len_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h14) |=> rdata[19:9] == $past(s.length) && rdata[28:20] == 9'h0)
        else $error("status length field wrong");
    overflow_a: assert property (@(posedge clk) disable iff (rst)
        $rose(s.raw[3]) |-> s.cause == 3'h6 && s.stat == 2'h3 && !s.sda_oe)
        else $error("overflow not aborted with nack");
    rfs_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (s.op == 2'h3 && s.length == 11'h7ff && s.st == i2cf_pkg::I2CF_TX && fall
         && s.bitcnt == 4'h8 && s.ctrl[0]) |=> s.length == 11'h000)
        else $error("read length did not wrap");
    dual_clear_a: assert property (@(posedge clk) disable iff (rst)
        (stop_c || !s.ctrl[0]) |=> !s.dual)
        else $error("dual flag not cleared");
    rx_pop_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h18 && s.cnt != 5'h00 && s.ctrl[0])
        |=> rdata[7:0] == $past(s.mem[s.rp]) && s.rp == $past(s.rp) + 4'h1)
        else $error("data port read did not pop");
    stretch_a: assert property (@(posedge clk) disable iff (rst)
        (s.st == i2cf_pkg::I2CF_WRX && fall && s.bitcnt == 4'h8 && full
         && s.length != 11'h7ff && s.ctrl[0]) |=> s.scl_oe && s.st == i2cf_pkg::I2CF_STRETCH)
        else $error("full fifo did not stretch scl");
    wts_req_a: assert property (@(posedge clk) disable iff (rst)
        ($past(s.st) == i2cf_pkg::I2CF_ADDR && s.st == i2cf_pkg::I2CF_ACK && s.op == 2'h2)
        |-> s.raw[2])
        else $error("write request flag missing");
    tx_thresh_a: assert property (@(posedge clk) disable iff (rst)
        (s.ctrl[0] && tx_fifo_count <= s.txthr) |=> s.raw[0])
        else $error("tx nearly empty flag missing");
    rx_thresh_a: assert property (@(posedge clk) disable iff (rst)
        (s.ctrl[0] && {5'h00, s.cnt} >= s.rxthr) |=> s.raw[1])
        else $error("rx nearly full flag missing");
endmodule

/* src/i2cf_pkg.sv */
package i2cf_pkg;
    // register byte offsets
    localparam logic [7:0] I2CF_CTRL_OFS   = 8'h00;
    localparam logic [7:0] I2CF_SADDR_OFS  = 8'h04;
    localparam logic [7:0] I2CF_RAW_OFS    = 8'h08;
    localparam logic [7:0] I2CF_MASK_OFS   = 8'h0c;
    localparam logic [7:0] I2CF_STAT_OFS   = 8'h14;
    localparam logic [7:0] I2CF_RXDATA_OFS = 8'h18;
    localparam logic [7:0] I2CF_TXTHR_OFS  = 8'h1c;
    localparam logic [7:0] I2CF_RXTHR_OFS  = 8'h20;
    // control bits
    localparam int I2CF_CTRL_PE    = 0;
    localparam int I2CF_CTRL_DMA   = 1;
    localparam int I2CF_CTRL_GCALL = 2;
    localparam int I2CF_CTRL_W     = 3;
    localparam logic [2:0] I2CF_CTRL_RST = 3'h0;
    // slave address register fields
    localparam int I2CF_SA_LSB  = 0;
    localparam int I2CF_DSA_LSB = 8;
    localparam logic [6:0] I2CF_SA_RST = 7'h00;
    // raw interrupt and mask bits
    localparam int I2CF_IRQ_TXNE = 0;
    localparam int I2CF_IRQ_RXNF = 1;
    localparam int I2CF_IRQ_WREQ = 2;
    localparam int I2CF_IRQ_OVF  = 3;
    localparam int I2CF_IRQ_W    = 4;
    // status register layout
    localparam int I2CF_ST_OP_LSB    = 0;
    localparam int I2CF_ST_STAT_LSB  = 2;
    localparam int I2CF_ST_CAUSE_LSB = 4;
    localparam int I2CF_ST_TYPE_LSB  = 7;
    localparam int I2CF_ST_LEN_LSB   = 9;
    localparam int I2CF_ST_DUAL      = 29;
    localparam logic [1:0] I2CF_OP_MW  = 2'h0;
    localparam logic [1:0] I2CF_OP_WTS = 2'h2;
    localparam logic [1:0] I2CF_OP_RFS = 2'h3;
    localparam logic [1:0] I2CF_STAT_NOP   = 2'h0;
    localparam logic [1:0] I2CF_STAT_BUSY  = 2'h1;
    localparam logic [1:0] I2CF_STAT_OK    = 2'h2;
    localparam logic [1:0] I2CF_STAT_ABORT = 2'h3;
    localparam logic [2:0] I2CF_CAUSE_NONE   = 3'h0;
    localparam logic [2:0] I2CF_CAUSE_BSTART = 3'h4;
    localparam logic [2:0] I2CF_CAUSE_BSTOP  = 3'h5;
    localparam logic [2:0] I2CF_CAUSE_SLAVE_WRITE_OVERFLOW   = 3'h6;
    localparam logic [1:0] I2CF_TYPE_FRAME = 2'h0;
    localparam logic [1:0] I2CF_TYPE_GCALL = 2'h1;
    localparam logic [1:0] I2CF_TYPE_HWGC  = 2'h2;
    localparam logic [10:0] I2CF_LEN_MAX   = 11'h7ff;
    // thresholds and rx fifo
    localparam logic [9:0] I2CF_THR_RST = 10'h000;
    localparam int I2CF_RX_DEPTH = 16;
    localparam int I2CF_RXPTR_W  = 4;
    localparam int I2CF_RXCNT_W  = 5;
    localparam logic [4:0] I2CF_RX_FULL = 5'h10;
    // slave engine states
    typedef enum logic [6:0] {
        I2CF_IDLE    = 7'h01,
        I2CF_ADDR    = 7'h02,
        I2CF_ACK     = 7'h04,
        I2CF_WRX     = 7'h08,
        I2CF_STRETCH = 7'h10,
        I2CF_TX      = 7'h20,
        I2CF_MACK    = 7'h40
    } i2cf_state_t;
endpackage

/* src/i2cf_sync.sv */
`timescale 1ns/1ns
module i2cf_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } i2cf_sync_t;

    i2cf_sync_t s;
    i2cf_sync_t next_s;

    // two stages; idle level of the bus lines is high
    always_comb
    begin
        next_s.meta   = din;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '{meta: '1, stable: '1};
        else
            s <= next_s;
    end

    assign dout = s.stable;
endmodule

/* tb/i2cf_master_model.sv */
`timescale 1ns/1ns
module i2cf_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    // released lines float high on the pull-ups
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // scl only moves inside frames; a stretching slave holds the high phase off
    task automatic bit_io(input logic b, output logic s);
        sda_oe = !b;
        #32 scl_oe = 1'b0;
        wait (scl === 1'b1);
        #32 s = sda;
        scl_oe = 1'b1;
    endtask
    // msb first, ninth clock samples the slave's answer
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // start drops sda while scl is high; stop drops it with scl low, then releases it with scl high
    task automatic start();
        sda_oe = 1'b1;
        #32 scl_oe = 1'b1;
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        #32 scl_oe = 1'b0;
        #32 sda_oe = 1'b0;
        #32;
    endtask
endmodule

/* tb/i2cf_rx_fifo_bench.sv */
`timescale 1ns/1ns
module i2cf_rx_fifo_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [9:0]  tx_fifo_count = 10'h000;
    logic [31:0] rdata;
    logic        irq, scl_oe, sda_oe, m_scl, m_sda, dma;
    int          error_cnt = 0;
    int          num_checks = 0;
    // wired-and lines with pull-ups
    wire logic scl = !(scl_oe | m_scl);
    wire logic sda = !(sda_oe | m_sda);
    always #2 clk = !clk;
    i2cf_rx_fifo dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .scl_in(scl),
        .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe, .tx_fifo_count,
        .tx_byte(8'ha5), .tx_pop(), .rx_dma_req(dma));
    i2cf_master_model mst (.scl, .sda, .scl_oe(m_scl), .sda_oe(m_sda));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        rreg(i2cf_pkg::I2CF_RXTHR_OFS, d);
        chk(d, 32'h00000000);
        wreg(i2cf_pkg::I2CF_TXTHR_OFS, 32'hffffffff);
        rreg(i2cf_pkg::I2CF_TXTHR_OFS, d);
        chk(d, 32'h000003ff);
        wreg(8'h40, 32'hffffffff);
        rreg(8'h40, d);
        chk(d, 32'h00000000);
    endtask
    // equal count sets the flag, one above lets it clear
    task automatic t_tx();
        logic [31:0] d;
        wreg(i2cf_pkg::I2CF_TXTHR_OFS, 32'h5);
        tx_fifo_count <= 10'h005;
        wreg(i2cf_pkg::I2CF_MASK_OFS, 32'h1);
        wreg(i2cf_pkg::I2CF_CTRL_OFS, 32'h1);
        rreg(i2cf_pkg::I2CF_RAW_OFS, d);
        chk({31'h0, d[0]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        tx_fifo_count <= 10'h006;
        rreg(i2cf_pkg::I2CF_RAW_OFS, d);
        rreg(i2cf_pkg::I2CF_RAW_OFS, d);
        chk({31'h0, d[0]}, 32'h0);
    endtask
    // one byte written to the second address, then a stop
    task automatic t_frame();
        logic [31:0] d;
        logic        ack;
        wreg(i2cf_pkg::I2CF_SADDR_OFS, 32'h00003355);
        wreg(i2cf_pkg::I2CF_RXTHR_OFS, 32'h1);
        wreg(i2cf_pkg::I2CF_CTRL_OFS, 32'h3);
        mst.start();
        mst.put(8'h66, ack);
        chk({31'h0, ack}, 32'h1);
        mst.put(8'hb1, ack);
        chk({31'h0, ack}, 32'h1);
        rreg(i2cf_pkg::I2CF_RAW_OFS, d);
        chk({28'h0, d[3:0]}, 32'h6);
        rreg(i2cf_pkg::I2CF_STAT_OFS, d);
        chk({18'h0, d[29], d[19:9], d[1:0]}, {18'h0, 1'b1, 11'h001, 2'h2});
        chk({31'h0, dma}, 32'h1);
        rreg(i2cf_pkg::I2CF_RXDATA_OFS, d);
        chk(d, 32'h0000008d);
        repeat (2) @(negedge clk);
        chk({31'h0, dma}, 32'h0);
        mst.stop();
        rreg(i2cf_pkg::I2CF_STAT_OFS, d);
        chk({29'h0, d[29], d[3:2]}, {29'h0, 1'b0, 2'h2});
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tx();
        t_frame();
        end_of_test();
    end
    // a stuck link clock would otherwise hang the run
    initial
    begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule
